// ===== logic/ssvi_top.sv
// Six-source vectored interrupt controller with two control registers
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module ssvi_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic ext_irq0_n,
    input wire logic ext_irq1_n,
    input wire logic cmp0_out,
    input wire logic tmr0_overflow,
    input wire logic tmr1_overflow,
    input wire logic adc_done,
    input wire logic phase_two_tick,
    input wire logic stack_full,
    input wire logic irq_exit_unmask,
    input wire logic subroutine_exit_plain,
    input wire logic call_ack,
    output logic call_req,
    output logic [7:0] call_vector,
    output logic wake,
    output logic test_mode
);
    ssvi_src_if src_bus ();

    ssvi_edge_catch u_edge (
        .clk(clk),
        .rst(rst),
        .src(src_bus)
    );

    assign src_bus.raw_in = {adc_done, tmr1_overflow, tmr0_overflow, cmp0_out, ext_irq1_n, ext_irq0_n};

    // Register and request state
    logic master_int_enable_r;
    logic master_int_enable_nxt;
    logic [5:0] en_r;
    logic [5:0] en_nxt;
    logic [5:0] flag_r;
    logic [5:0] flag_nxt;
    logic test_r;
    logic test_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    ssvi_pkg::ssvi_state_t state_r;
    ssvi_pkg::ssvi_state_t state_nxt;
    logic [2:0] src_r;
    logic [2:0] src_nxt;
    logic call_req_r;
    logic call_req_nxt;
    logic [7:0] vec_r;
    logic [7:0] vec_nxt;
    logic wake_r;
    logic wake_nxt;

    logic [5:0] pending;
    logic [2:0] winner;
    logic [5:0] clr_onehot;
    logic wr_main;
    logic wr_aux;

    assign wr_main = reg_wr && (reg_addr == ssvi_pkg::ADDR_CTRL_MAIN);
    assign wr_aux = reg_wr && (reg_addr == ssvi_pkg::ADDR_CTRL_AUX);

    // Qualified requests
    assign pending = flag_r & en_r & {ssvi_pkg::NUM_SRC{master_int_enable_r}};

    // Lowest index wins
    always_comb begin
        winner = ssvi_pkg::SRC_NONE;
        for (int i = ssvi_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (pending[i]) begin
                winner = 3'(i);
            end
        end
    end

    // Sequencer state
    always_comb begin
        state_nxt = state_r;
        src_nxt = src_r;
        call_req_nxt = call_req_r;
        vec_nxt = vec_r;
        clr_onehot = 6'h00;
        case (state_r)
            ssvi_pkg::SSVI_IDLE: begin
                if (phase_two_tick && !stack_full && winner != ssvi_pkg::SRC_NONE) begin
                    state_nxt = ssvi_pkg::SSVI_WAIT_ACK;
                    src_nxt = winner;
                    call_req_nxt = 1'b1;
                    vec_nxt = ssvi_pkg::VEC_BASE + 8'(ssvi_pkg::VEC_STEP * 8'(winner));
                end
            end
            ssvi_pkg::SSVI_WAIT_ACK: begin
                if (call_ack) begin
                    // Core pushes only the program counter then jumps
                    state_nxt = ssvi_pkg::SSVI_IDLE;
                    call_req_nxt = 1'b0;
                    clr_onehot = 6'(6'h01 << src_r);
                end
            end
            default: begin
                state_nxt = ssvi_pkg::SSVI_IDLE;
                call_req_nxt = 1'b0;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= ssvi_pkg::SSVI_IDLE;
            src_r <= 3'h0;
            call_req_r <= 1'b0;
            vec_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            src_r <= src_nxt;
            call_req_r <= call_req_nxt;
            vec_r <= vec_nxt;
        end
    end

    // Register fields by name
    logic ext0_enable;
    logic ext1_enable;
    logic cmp0_int_enable;
    logic tmr0_int_enable;
    logic tmr1_int_enable;
    logic adc_int_enable;
    logic ext0_req_flag;
    logic ext1_req_flag;
    logic cmp0_req_flag;
    logic tmr0_req_flag;
    logic tmr1_req_flag;
    logic adc_req_flag;

    assign ext0_enable = en_r[0];
    assign ext1_enable = en_r[1];
    assign cmp0_int_enable = en_r[2];
    assign tmr0_int_enable = en_r[3];
    assign tmr1_int_enable = en_r[4];
    assign adc_int_enable = en_r[5];
    assign ext0_req_flag = flag_r[0];
    assign ext1_req_flag = flag_r[1];
    assign cmp0_req_flag = flag_r[2];
    assign tmr0_req_flag = flag_r[3];
    assign tmr1_req_flag = flag_r[4];
    assign adc_req_flag = flag_r[5];

    // Write field decode
    logic wr_master;
    logic wr_test;
    logic [2:0] wr_en_lo;
    logic [2:0] wr_flag_lo;
    logic [2:0] wr_en_hi;
    logic [2:0] wr_flag_hi;
    logic [5:0] flag_wr_sel;
    logic [5:0] flag_wr_val;
    logic [5:0] flag_kept;

    assign wr_master = reg_wdata[ssvi_pkg::BIT_MASTER];
    assign wr_test = reg_wdata[ssvi_pkg::BIT_TEST];
    assign wr_en_lo = reg_wdata[ssvi_pkg::BIT_CMP0_EN:ssvi_pkg::BIT_EXT0_EN];
    assign wr_flag_lo = reg_wdata[ssvi_pkg::BIT_CMP0_FLAG:ssvi_pkg::BIT_EXT0_FLAG];
    assign wr_en_hi = reg_wdata[ssvi_pkg::BIT_ADC_EN:ssvi_pkg::BIT_TMR0_EN];
    assign wr_flag_hi = reg_wdata[ssvi_pkg::BIT_ADC_FLAG:ssvi_pkg::BIT_TMR0_FLAG];
    assign flag_wr_sel = {{3{wr_aux}}, {3{wr_main}}};
    assign flag_wr_val = {wr_flag_hi, wr_flag_lo};

    // Per-source flag: write, then ack clear, then event set
    generate
        for (genvar g = 0; g < ssvi_pkg::NUM_SRC; g++) begin : g_flag
            assign flag_kept[g] = flag_wr_sel[g] ? flag_wr_val[g] : flag_r[g];
            assign flag_nxt[g] = (flag_kept[g] && !clr_onehot[g]) || src_bus.event_pulse[g];
        end
    endgenerate

    // Control register next values
    always_comb begin
        master_int_enable_nxt = master_int_enable_r;
        en_nxt = en_r;
        test_nxt = test_r;
        if (wr_main) begin
            master_int_enable_nxt = wr_master;
            en_nxt[2:0] = wr_en_lo;
            test_nxt = wr_test;
        end
        if (wr_aux) begin
            en_nxt[5:3] = wr_en_hi;
        end
        if (clr_onehot != 6'h00) begin
            master_int_enable_nxt = 1'b0;
        end
        if (irq_exit_unmask) begin
            master_int_enable_nxt = 1'b1;
        end
    end

    // Control register state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            master_int_enable_r <= 1'b0;
            en_r <= 6'h00;
            flag_r <= 6'h00;
            test_r <= 1'b0;
        end else begin
            master_int_enable_r <= master_int_enable_nxt;
            en_r <= en_nxt;
            flag_r <= flag_nxt;
            test_r <= test_nxt;
        end
    end

    // Read data, zero outside the read slot
    always_comb begin
        rdata_nxt = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                ssvi_pkg::ADDR_CTRL_MAIN: begin
                    rdata_nxt = {
                        test_r,
                        cmp0_req_flag,
                        ext1_req_flag,
                        ext0_req_flag,
                        cmp0_int_enable,
                        ext1_enable,
                        ext0_enable,
                        master_int_enable_r
                    };
                end
                ssvi_pkg::ADDR_CTRL_AUX: begin
                    rdata_nxt = {
                        1'b0,
                        adc_req_flag,
                        tmr1_req_flag,
                        tmr0_req_flag,
                        1'b0,
                        adc_int_enable,
                        tmr1_int_enable,
                        tmr0_int_enable
                    };
                end
                default: begin
                    rdata_nxt = 8'h00;
                end
            endcase
        end
    end

    // Read data register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_r <= ssvi_pkg::RESET_CTRL;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Any flag wakes a halted device
    always_comb begin
        wake_nxt = |flag_nxt;
    end

    // Wake register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wake_r <= 1'b0;
        end else begin
            wake_r <= wake_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign call_req = call_req_r;
    assign call_vector = vec_r;
    assign wake = wake_r;
    assign test_mode = test_r;
endmodule
`default_nettype wire

// ===== logic/ssvi_pkg.sv
// Package of register map, field positions, vectors and states for the vectored interrupt block
package ssvi_pkg;
    localparam logic [7:0] ADDR_CTRL_MAIN = 8'h0b;
    localparam logic [7:0] ADDR_CTRL_AUX = 8'h1e;
    localparam int NUM_SRC = 6;
    // Main control register bits
    localparam int BIT_MASTER = 0;
    localparam int BIT_EXT0_EN = 1;
    localparam int BIT_CMP0_EN = 3;
    localparam int BIT_EXT0_FLAG = 4;
    localparam int BIT_CMP0_FLAG = 6;
    localparam int BIT_TEST = 7;
    // Aux control register bits
    localparam int BIT_TMR0_EN = 0;
    localparam int BIT_ADC_EN = 2;
    localparam int BIT_TMR0_FLAG = 4;
    localparam int BIT_ADC_FLAG = 6;
    localparam logic [7:0] RESET_CTRL = 8'h00;
    localparam logic [7:0] VEC_STEP = 8'h04;
    localparam logic [7:0] VEC_BASE = 8'h04;
    localparam logic [2:0] SRC_NONE = 3'h7;
    typedef enum logic [0:0] {SSVI_IDLE, SSVI_WAIT_ACK} ssvi_state_t;
endpackage

// ===== logic/ssvi_src_if.sv
// Interface carrying per-source raw input and event bits between the top and the edge catcher
`timescale 1ns/1ps
`default_nettype none
interface ssvi_src_if;
    logic [5:0] event_pulse;
    logic [5:0] raw_in;
    modport catcher (input raw_in, output event_pulse);
    modport user (output raw_in, input event_pulse);
endinterface
`default_nettype wire

// ===== logic/ssvi_edge_catch.sv
// Edge detector turning source levels and pulses into one-cycle events
`timescale 1ns/1ps
`default_nettype none
module ssvi_edge_catch (
    input wire logic clk,
    input wire logic rst,
    ssvi_src_if.catcher src
);
    logic [2:0] prev_r;
    logic [2:0] prev_nxt;
    logic [5:0] ev_r;
    logic [5:0] ev_nxt;

    always_comb begin
        prev_nxt = src.raw_in[2:0];
        // Falling edges on both pins and the comparator, pulses pass through
        ev_nxt = {src.raw_in[5:3], prev_r & ~src.raw_in[2:0]};
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_r <= 3'h7;
            ev_r <= 6'h00;
        end else begin
            prev_r <= prev_nxt;
            ev_r <= ev_nxt;
        end
    end

    assign src.event_pulse = ev_r;
endmodule
`default_nettype wire

// ===== test/ssvi_core_model.sv
// Core sequencer model accepting vectored calls after a set delay
`timescale 1ns/1ps
`default_nettype none
module ssvi_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic call_req,
    input wire logic [7:0] dly,
    output logic call_ack
);
    logic [7:0] cnt_r;
    // One ack per call, dly plus one cycles after call_req rises
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 8'h00;
            call_ack <= 1'b0;
        end else if (!call_req) begin
            cnt_r <= 8'h00;
            call_ack <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 8'h01;
            call_ack <= (cnt_r == dly);
        end
    end
endmodule
`default_nettype wire

// ===== test/ssvi_monitor.sv
// Checker of register reads and call handshake
`timescale 1ns/1ps
`default_nettype none
module ssvi_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic phase_two_tick,
    input wire logic stack_full,
    input wire logic call_ack,
    input wire logic call_req,
    input wire logic [7:0] call_vector
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_rd_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("rdata outside slot");
    a_aux_spare: assert property (reg_rd && reg_addr == ssvi_pkg::ADDR_CTRL_AUX |=>
        reg_rdata[3] == 1'b0 && reg_rdata[7] == 1'b0) else $error("aux spare set");
    a_unmapped_zero: assert property (reg_rd && reg_addr != ssvi_pkg::ADDR_CTRL_AUX &&
        reg_addr != ssvi_pkg::ADDR_CTRL_MAIN |=> reg_rdata == 8'h00) else $error("unmapped data");
    a_req_hold: assert property (call_req && !call_ack |=> call_req && $stable(call_vector))
        else $error("call dropped");
    a_req_drop: assert property (call_req && call_ack |=> !call_req) else $error("call stuck");
    a_req_start: assert property ($rose(call_req) |-> $past(phase_two_tick) && !$past(stack_full))
        else $error("call off tick");
    a_full_block: assert property (phase_two_tick && stack_full && !call_req |=> !call_req)
        else $error("call on full");
    a_vec_legal: assert property (call_req |-> call_vector inside {8'h04, 8'h08, 8'h0c, 8'h10,
        8'h14, 8'h18}) else $error("bad vector");
    cover property (call_req && call_ack);
    cover property (phase_two_tick && stack_full);
    cover property (reg_rd && reg_addr == ssvi_pkg::ADDR_CTRL_MAIN);
endmodule
bind ssvi_top ssvi_monitor ssvi_monitor_inst (.*);
`default_nettype wire

// ===== test/test_six_source_vectored_irq.sv
// Testbench for the vectored interrupt block
`timescale 1ns/1ps
`default_nettype none
module test_six_source_vectored_irq;
    logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, ext_irq0_n = 1, ext_irq1_n = 1, cmp0_out = 1;
    logic tmr0_overflow = 0, tmr1_overflow = 0, adc_done = 0, phase_two_tick = 0, stack_full = 0;
    logic irq_exit_unmask = 0, subroutine_exit_plain = 0, call_ack, call_req, wake, test_mode;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, call_vector, dly = 0;
    logic [5:0] f;
    int n_mismatch = 0, checked = 0, cyc = 0;
    localparam logic [7:0] MA = ssvi_pkg::ADDR_CTRL_MAIN;
    localparam logic [7:0] AU = ssvi_pkg::ADDR_CTRL_AUX;
    always #2 clk = ~clk;
    ssvi_top ssvi_top_inst (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_irq0_n(ext_irq0_n), .ext_irq1_n(ext_irq1_n),
        .cmp0_out(cmp0_out), .tmr0_overflow(tmr0_overflow), .tmr1_overflow(tmr1_overflow),
        .adc_done(adc_done), .phase_two_tick(phase_two_tick), .stack_full(stack_full),
        .irq_exit_unmask(irq_exit_unmask), .subroutine_exit_plain(subroutine_exit_plain),
        .call_ack(call_ack), .call_req(call_req), .call_vector(call_vector), .wake(wake),
        .test_mode(test_mode)
    );
    ssvi_core_model ssvi_core_model_inst (
        .clk(clk), .rst(rst), .call_req(call_req), .dly(dly), .call_ack(call_ack)
    );
    task automatic results();
        if (n_mismatch == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            results();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    task automatic strobe(input logic [2:0] s);
        @(posedge clk);
        {irq_exit_unmask, subroutine_exit_plain, phase_two_tick} <= s;
        @(posedge clk);
        {irq_exit_unmask, subroutine_exit_plain, phase_two_tick} <= 3'h0;
        #1;
    endtask
    task automatic wait_req(input logic v);
        for (int k = 0; k < 20 && call_req !== v; k++) @(posedge clk) #1;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(MA, 8'h00);
        rd(AU, 8'h00);
        wr(AU, 8'h0f);
        rd(AU, 8'h07);
        wr(MA, 8'h0e);
        rd(MA, 8'h0e);
        rd(8'h0c, 8'h00);
        @(posedge clk);
        {ext_irq0_n, ext_irq1_n, cmp0_out} <= 3'h0;
        {tmr0_overflow, tmr1_overflow, adc_done} <= 3'h7;
        @(posedge clk);
        {tmr0_overflow, tmr1_overflow, adc_done} <= 3'h0;
        rd(MA, 8'h7e);
        rd(AU, 8'h77);
        chk({7'h0, wake}, 8'h01);
        strobe(3'h1);
        chk({7'h0, call_req}, 8'h00);
        stack_full <= 1'b1;
        wr(MA, 8'h7f);
        chk({7'h0, test_mode}, 8'h00);
        strobe(3'h1);
        chk({7'h0, call_req}, 8'h00);
        rd(MA, 8'h7f);
        stack_full <= 1'b0;
        f = 6'h3f;
        for (int i = 0; i < 6; i++) begin
            dly <= 8'(i);
            strobe(3'h1);
            wait_req(1'b1);
            chk(call_vector, 8'h04 + 8'(4 * i));
            wait_req(1'b0);
            f[i] = 1'b0;
            strobe(3'h2);
            rd(MA, {1'b0, f[2:0], 4'he});
            rd(AU, {1'b0, f[5:3], 4'h7});
            strobe(3'h4);
            repeat (3) @(posedge clk);
            #1;
            chk({7'h0, call_req}, 8'h00);
        end
        @(posedge clk);
        tmr0_overflow <= 1'b1;
        @(posedge clk);
        tmr0_overflow <= 1'b0;
        reg_addr <= AU;
        reg_wdata <= 8'h07;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        rd(AU, 8'h17);
        strobe(3'h1);
        wait_req(1'b1);
        chk(call_vector, 8'h10);
        wait_req(1'b0);
        rd(MA, 8'h0e);
        wr(MA, 8'h13);
        strobe(3'h1);
        wait_req(1'b1);
        chk(call_vector, 8'h04);
        wait_req(1'b0);
        chk({7'h0, wake}, 8'h00);
        results();
    end
endmodule
`default_nettype wire
